//--- tb_transfer_switch_status_regs.sv
// Self-checking bench of the transfer switch status bank.
// Assumes the client model and the checker are compiled first.
`timescale 1ns/100ps

module tb_transfer_switch_status_regs;
    logic        clk_in, rst_b_in, rv, rw, rsv, rse, at_n, at_a, at_o, shs, gns, sha;
    logic [15:0] ra, rsd, last, t;
    logic [7:0]  rsc, v1, c1, v2, c2, m;
    logic [1:0]  ns, as, gst;
    logic [2:0]  pole, mode;
    int          n_mismatch = 0;
    int          n_checks = 0;

    tss_status_bank u_dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(rv), .req_write_in(rw),
        .req_addr_in(ra), .rsp_valid_out(rsv), .rsp_data_out(rsd), .rsp_exc_out(rse),
        .rsp_exc_code_out(rsc), .at_normal_in(at_n), .at_alternate_in(at_a),
        .at_off_in(at_o), .normal_state_in(ns), .alternate_state_in(as),
        .src1_valid_in(v1), .src1_cond_in(c1), .source_two_valid_in(v2),
        .source_two_cond_in(c2), .pole_count_in(pole), .shed_supported_in(shs),
        .gen_supported_in(gns), .shed_active_in(sha), .gen_state_in(gst), .mode_in(mode));
    tss_client u_cli (
        .clk_in(clk_in), .req_valid_out(rv), .req_write_out(rw), .req_addr_out(ra),
        .rsp_valid_in(rsv), .rsp_data_in(rsd), .rsp_exc_in(rse), .rsp_exc_code_in(rsc));

    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic rd(input logic wr, input int num, input logic [15:0] exp, input logic [7:0] ec);
        logic [7:0] c;
        logic       x, ok;
        u_cli.xfer(wr, num[15:0], last, x, c, ok);
        chk("answer", 16'h0001, {15'h0000, ok});
        chk("data", exp, last);
        chk("exception", {15'h0000, ec != 8'h00}, {15'h0000, x});
        chk("code", {8'h00, ec}, {8'h00, c});
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task automatic do_reset(input logic [2:0] p);
        rst_b_in = 1'b0;
        pole = p;
        repeat (3) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #1;
    endtask
    task automatic summarize;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        repeat (4000) @(posedge clk_in);
        n_mismatch++;
        summarize();
    end

    initial begin
        logic [2:0]  pp[5] = '{3'b100, 3'b010, 3'b001, 3'b000, 3'b110};
        logic [15:0] pe[5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0000, 16'h0000};
        logic [2:0]  pl[3] = '{3'h3, 3'h2, 3'h4};
        logic [7:0]  mk[3] = '{8'hf4, 8'hf0, 8'hff};
        int          un[7] = '{1000, 1002, 1004, 1010, 1020, 1025, 1101};
        {rst_b_in, at_n, at_a, at_o, shs, gns, sha, ns, as, gst, mode} = '0;
        {v1, c1, v2, c2} = {8'ha5, 8'h5e, 8'h3c, 8'hc3};
        shs = 1'b1;
        gns = 1'b1;
        do_reset(3'h4);
        for (int i = 0; i < 5; i++) begin
            {at_n, at_a, at_o} = pp[i];
            settle();
            rd(1'b0, 1001, pe[i], 8'h00);
        end
        for (int s = 0; s < 3; s++) begin
            ns = s[1:0];
            as = 2'h2 - s[1:0];
            settle();
            rd(1'b0, 1003, 16'(s), 8'h00);
            rd(1'b0, 1005, 16'(2 - s), 8'h00);
        end
        ns = 2'h3;
        settle();
        rd(1'b0, 1003, 16'h0002, 8'h00);
        for (int i = 0; i < 3; i++) begin
            m = mk[i];
            do_reset(pl[i]);
            rd(1'b0, 1006, {8'h00, v1 & m}, 8'h00);
            t = last;
            rd(1'b0, 1007, {8'h00, c1 & m}, 8'h00);
            chk("usable", {8'h00, v1 & c1 & m}, {8'h00, u_cli.usable(t[7:0], last[7:0])});
            rd(1'b0, 1008, {8'h00, v2 & m}, 8'h00);
            rd(1'b0, 1009, {8'h00, c2 & m}, 8'h00);
        end
        rd(1'b0, 1021, 16'h0001, 8'h00);
        rd(1'b0, 1023, 16'h0001, 8'h00);
        for (int i = 0; i < 2; i++) begin
            sha = i[0];
            settle();
            rd(1'b0, 1022, 16'(i), 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            gst = i[1:0];
            settle();
            rd(1'b0, 1024, (i == 3) ? 16'h0002 : 16'(i), 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            mode = i[2:0];
            settle();
            rd(1'b0, 1100, 16'(i), 8'h00);
        end
        foreach (un[i]) rd(1'b0, un[i], 16'h0000, 8'h02);
        rd(1'b1, 1002, 16'h0000, 8'h02);
        mode = 3'h7;
        settle();
        rd(1'b1, 1100, 16'h0000, 8'h00);
        rd(1'b0, 1100, 16'h0005, 8'h00);
        {shs, gns} = 2'b00;
        do_reset(3'h4);
        rd(1'b0, 1021, 16'h0000, 8'h00);
        rd(1'b0, 1022, 16'h0000, 8'h00);
        rd(1'b0, 1023, 16'h0000, 8'h00);
        rd(1'b0, 1024, 16'h0002, 8'h00);
        summarize();
    end
endmodule

//--- tss_client.sv
// Remote client model issuing one register request at a time.
// Assumes the bank answers on the edge that takes the request.
`timescale 1ns/100ps

module tss_client (
    // Clock
    input  wire logic        clk_in,
    // Request
    output logic             req_valid_out,
    output logic             req_write_out,
    output logic [15:0]      req_addr_out,
    // Answer
    input  wire logic        rsp_valid_in,
    input  wire logic [15:0] rsp_data_in,
    input  wire logic        rsp_exc_in,
    input  wire logic [7:0]  rsp_exc_code_in
);
    initial begin
        req_valid_out = 1'b0;
        req_write_out = 1'b0;
        req_addr_out  = 16'h0000;
    end

    // Condition trusted only where valid
    function automatic logic [7:0] usable(input logic [7:0] v, input logic [7:0] c);
        return v & c;
    endfunction

    // One register per request
    task automatic xfer(input logic wr, input logic [15:0] num, output logic [15:0] d,
                        output logic x, output logic [7:0] c, output logic ok);
        @(posedge clk_in);
        #1;
        req_write_out = wr;
        req_addr_out  = num - 16'h0001;
        req_valid_out = 1'b1;
        @(posedge clk_in);
        #1;
        req_valid_out = 1'b0;
        req_write_out = ~wr;
        req_addr_out  = ~req_addr_out;
        ok = rsp_valid_in;
        d  = rsp_data_in;
        x  = rsp_exc_in;
        c  = rsp_exc_code_in;
    endtask
endmodule

//--- tss_pkg.sv
// Types shared by the transfer switch status bank.
// Assumes the constants header supplies all other numeric codes.
package tss_pkg;

    typedef enum logic [1:0] {
        TSS_SRC_IN_RANGE   = 2'b00,
        TSS_SRC_OUT_RANGE  = 2'b01,
        TSS_SRC_NO_VOLTAGE = 2'b10
    } tss_src_state_e;

    typedef enum logic [1:0] {
        TSS_GEN_INACTIVE = 2'b00,
        TSS_GEN_ACTIVE   = 2'b01,
        TSS_GEN_UNABLE   = 2'b10
    } tss_gen_state_e;

    typedef enum logic [2:0] {
        TSS_MODE_INIT      = 3'b000,
        TSS_MODE_AUTO      = 3'b001,
        TSS_MODE_TEST      = 3'b010,
        TSS_MODE_VOLUNTARY = 3'b011,
        TSS_MODE_REMOTE    = 3'b100,
        TSS_MODE_LOCAL     = 3'b101
    } tss_mode_e;

endpackage

//--- tss_regs.svh
// Frame addresses, encodings and field positions of the status bank.
// Assumes frame addresses arrive already as register number minus one.
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH

// Frame addresses
`define TSS_ADDR_SWITCH_POSITION    16'h03e8
`define TSS_ADDR_NORMAL_STATE       16'h03ea
`define TSS_ADDR_ALTERNATE_STATE    16'h03ec
`define TSS_ADDR_SRC1_VALIDITY      16'h03ed
`define TSS_ADDR_SRC1_CONDITIONS    16'h03ee
`define TSS_ADDR_SRC2_VALIDITY      16'h03ef
`define TSS_ADDR_SRC2_CONDITIONS    16'h03f0
`define TSS_ADDR_SHED_CAPABILITY    16'h03fc
`define TSS_ADDR_SHED_STATE         16'h03fd
`define TSS_ADDR_GEN_CAPABILITY     16'h03fe
`define TSS_ADDR_GEN_STATE          16'h03ff
`define TSS_ADDR_OPERATING_MODE     16'h044b

// Switch position codes
`define TSS_POS_NORMAL              16'h0001
`define TSS_POS_ALTERNATE           16'h0002
`define TSS_POS_OFF                 16'h0004
`define TSS_POS_ERROR               16'h0000

// Capability codes
`define TSS_SUPPORTED               16'h0001
`define TSS_NOT_SUPPORTED           16'h0000

// Condition bit positions
`define TSS_BIT_PHASE_SEQ           0
`define TSS_BIT_NEUTRAL_POS         1
`define TSS_BIT_UNBALANCE           2
`define TSS_BIT_NEUTRAL_LOSS        3

// Pole counts
`define TSS_POLES_THREE             3'h3
`define TSS_POLES_FOUR              3'h4

// Exception code and reset values
`define TSS_EXC_NONE                8'h00
`define TSS_EXC_ILLEGAL_ADDR        8'h02
`define TSS_ZERO16                  16'h0000
`define TSS_ZERO8                   8'h00

`endif

//--- tss_status_bank.sv
// Read-only status register bank of a transfer switching controller.
// Assumes the frame decoder runs on clk_in and status pins are asynchronous.
`timescale 1ns/100ps
`include "tss_regs.svh"

module tss_status_bank (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // Register request from frame decoder
    input  wire logic        req_valid_in,
    input  wire logic        req_write_in,
    input  wire logic [15:0] req_addr_in,
    // Register answer
    output logic             rsp_valid_out,
    output logic [15:0]      rsp_data_out,
    output logic             rsp_exc_out,
    output logic [7:0]       rsp_exc_code_out,
    // Switch position sensing
    input  wire logic        at_normal_in,
    input  wire logic        at_alternate_in,
    input  wire logic        at_off_in,
    // Source supervision
    input  wire logic [1:0]  normal_state_in,
    input  wire logic [1:0]  alternate_state_in,
    input  wire logic [7:0]  src1_valid_in,
    input  wire logic [7:0]  src1_cond_in,
    input  wire logic [7:0]  source_two_valid_in,
    input  wire logic [7:0]  source_two_cond_in,
    // Straps
    input  wire logic [2:0]  pole_count_in,
    input  wire logic        shed_supported_in,
    input  wire logic        gen_supported_in,
    // Function status
    input  wire logic        shed_active_in,
    input  wire logic [1:0]  gen_state_in,
    input  wire logic [2:0]  mode_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for all status pins
    // Request port shares clk_in and skips them

    localparam int PIN_W = 50;

    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic [PIN_W-1:0] pin_raw;

    assign pin_raw = {at_normal_in, at_alternate_in, at_off_in,
                      normal_state_in, alternate_state_in,
                      src1_valid_in, src1_cond_in,
                      source_two_valid_in, source_two_cond_in,
                      pole_count_in, shed_supported_in, gen_supported_in,
                      shed_active_in, gen_state_in, mode_in};

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    logic        s_at_normal;
    logic        s_at_alternate;
    logic        s_at_off;
    logic [1:0]  s_normal_state;
    logic [1:0]  s_alternate_state;
    logic [7:0]  s_src1_valid;
    logic [7:0]  s_src1_cond;
    logic [7:0]  s_src2_valid;
    logic [7:0]  s_src2_cond;
    logic [2:0]  s_pole_count;
    logic        s_shed_supported;
    logic        s_gen_supported;
    logic        s_shed_active;
    logic [1:0]  s_gen_state;
    logic [2:0]  s_mode;

    assign {s_at_normal, s_at_alternate, s_at_off,
            s_normal_state, s_alternate_state,
            s_src1_valid, s_src1_cond,
            s_src2_valid, s_src2_cond,
            s_pole_count, s_shed_supported, s_gen_supported,
            s_shed_active, s_gen_state, s_mode} = pin_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Straps captured once after reset release
    // A strap change needs a fresh reset

    logic        strap_taken;
    logic [2:0]  pole_count;
    logic        shed_supported;
    logic        gen_supported;
    logic [1:0]  strap_wait;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            strap_wait     <= 2'h0;
            strap_taken    <= 1'b0;
            pole_count     <= 3'h0;
            shed_supported <= 1'b0;
            gen_supported  <= 1'b0;
        end else if (!strap_taken) begin
            if (strap_wait == 2'h2) begin
                strap_taken    <= 1'b1;
                pole_count     <= s_pole_count;
                shed_supported <= s_shed_supported;
                gen_supported  <= s_gen_supported;
            end else begin
                strap_wait <= strap_wait + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pole-count masks for condition bits
    // Bits that do not apply read zero

    logic       is_four_pole;
    logic       is_three_or_four_pole;
    logic [7:0] pole_mask;

    assign is_four_pole          = (pole_count == `TSS_POLES_FOUR);
    assign is_three_or_four_pole = is_four_pole || (pole_count == `TSS_POLES_THREE);

    always_comb begin
        pole_mask                       = 8'hff;
        pole_mask[`TSS_BIT_PHASE_SEQ]    = is_four_pole;
        pole_mask[`TSS_BIT_NEUTRAL_POS]  = is_four_pole;
        pole_mask[`TSS_BIT_NEUTRAL_LOSS] = is_four_pole;
        pole_mask[`TSS_BIT_UNBALANCE]    = is_three_or_four_pole;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switch position register
    // None or several sense lines high reads as error

    logic [15:0] switch_position;
    logic [15:0] next_switch_position;

    always_comb begin
        if (s_at_normal && !s_at_alternate && !s_at_off) begin
            next_switch_position = `TSS_POS_NORMAL;
        end else if (!s_at_normal && s_at_alternate && !s_at_off) begin
            next_switch_position = `TSS_POS_ALTERNATE;
        end else if (!s_at_normal && !s_at_alternate && s_at_off) begin
            next_switch_position = `TSS_POS_OFF;
        end else begin
            next_switch_position = `TSS_POS_ERROR;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            switch_position <= `TSS_POS_ERROR;
        end else begin
            switch_position <= next_switch_position;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source state registers

    tss_pkg::tss_src_state_e normal_state;
    tss_pkg::tss_src_state_e alternate_state;

    tss_pkg::tss_src_state_e next_normal_state;
    tss_pkg::tss_src_state_e next_alternate_state;

    // Code 3 reads as no voltage
    always_comb begin
        case (s_normal_state)
            2'h0:    next_normal_state = tss_pkg::TSS_SRC_IN_RANGE;
            2'h1:    next_normal_state = tss_pkg::TSS_SRC_OUT_RANGE;
            default: next_normal_state = tss_pkg::TSS_SRC_NO_VOLTAGE;
        endcase
    end

    always_comb begin
        case (s_alternate_state)
            2'h0:    next_alternate_state = tss_pkg::TSS_SRC_IN_RANGE;
            2'h1:    next_alternate_state = tss_pkg::TSS_SRC_OUT_RANGE;
            default: next_alternate_state = tss_pkg::TSS_SRC_NO_VOLTAGE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            normal_state    <= tss_pkg::TSS_SRC_NO_VOLTAGE;
            alternate_state <= tss_pkg::TSS_SRC_NO_VOLTAGE;
        end else begin
            normal_state    <= next_normal_state;
            alternate_state <= next_alternate_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Validity and condition registers

    logic [7:0] src1_validity;
    logic [7:0] src1_conditions;
    logic [7:0] src2_validity;
    logic [7:0] src2_conditions;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            src1_validity   <= `TSS_ZERO8;
            src1_conditions <= `TSS_ZERO8;
            src2_validity   <= `TSS_ZERO8;
            src2_conditions <= `TSS_ZERO8;
        end else begin
            src1_validity   <= s_src1_valid & pole_mask;
            src1_conditions <= s_src1_cond & pole_mask;
            src2_validity   <= s_src2_valid & pole_mask;
            src2_conditions <= s_src2_cond & pole_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load shedding, generator control and mode

    logic                    shed_active;
    tss_pkg::tss_gen_state_e gen_state;
    tss_pkg::tss_mode_e      operating_mode;

    // Unsupported shedding never reads active
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            shed_active <= 1'b0;
        end else begin
            shed_active <= shed_supported && s_shed_active;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            gen_state <= tss_pkg::TSS_GEN_INACTIVE;
        end else if (!gen_supported) begin
            gen_state <= tss_pkg::TSS_GEN_UNABLE;
        end else if (s_gen_state == 2'h0) begin
            gen_state <= tss_pkg::TSS_GEN_INACTIVE;
        end else if (s_gen_state == 2'h1) begin
            gen_state <= tss_pkg::TSS_GEN_ACTIVE;
        end else begin
            gen_state <= tss_pkg::TSS_GEN_UNABLE;
        end
    end

    // Codes 6 and 7 keep the last legal mode
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            operating_mode <= tss_pkg::TSS_MODE_INIT;
        end else if (s_mode <= tss_pkg::TSS_MODE_LOCAL) begin
            operating_mode <= tss_pkg::tss_mode_e'(s_mode);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    // Frame address is register number minus one

    logic [15:0] next_rsp_data;
    logic        next_hit;

    always_comb begin
        next_rsp_data = `TSS_ZERO16;
        next_hit      = 1'b1;
        if (req_addr_in == `TSS_ADDR_SWITCH_POSITION) begin
            next_rsp_data = switch_position;
        end else if (req_addr_in == `TSS_ADDR_NORMAL_STATE) begin
            next_rsp_data = {14'h0000, normal_state};
        end else if (req_addr_in == `TSS_ADDR_ALTERNATE_STATE) begin
            next_rsp_data = {14'h0000, alternate_state};
        end else if (req_addr_in == `TSS_ADDR_SRC1_VALIDITY) begin
            next_rsp_data = {`TSS_ZERO8, src1_validity};
        end else if (req_addr_in == `TSS_ADDR_SRC1_CONDITIONS) begin
            next_rsp_data = {`TSS_ZERO8, src1_conditions};
        end else if (req_addr_in == `TSS_ADDR_SRC2_VALIDITY) begin
            next_rsp_data = {`TSS_ZERO8, src2_validity};
        end else if (req_addr_in == `TSS_ADDR_SRC2_CONDITIONS) begin
            next_rsp_data = {`TSS_ZERO8, src2_conditions};
        end else if (req_addr_in == `TSS_ADDR_SHED_CAPABILITY) begin
            next_rsp_data = shed_supported ? `TSS_SUPPORTED : `TSS_NOT_SUPPORTED;
        end else if (req_addr_in == `TSS_ADDR_SHED_STATE) begin
            next_rsp_data = {15'h0000, shed_active};
        end else if (req_addr_in == `TSS_ADDR_GEN_CAPABILITY) begin
            next_rsp_data = gen_supported ? `TSS_SUPPORTED : `TSS_NOT_SUPPORTED;
        end else if (req_addr_in == `TSS_ADDR_GEN_STATE) begin
            next_rsp_data = {14'h0000, gen_state};
        end else if (req_addr_in == `TSS_ADDR_OPERATING_MODE) begin
            next_rsp_data = {13'h0000, operating_mode};
        end else begin
            next_hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer registers
    // Writes answer with zero and change nothing

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rsp_valid_out    <= 1'b0;
            rsp_data_out     <= `TSS_ZERO16;
            rsp_exc_out      <= 1'b0;
            rsp_exc_code_out <= `TSS_EXC_NONE;
        end else begin
            rsp_valid_out <= req_valid_in;
            if (req_valid_in) begin
                if (!next_hit) begin
                    rsp_data_out     <= `TSS_ZERO16;
                    rsp_exc_out      <= 1'b1;
                    rsp_exc_code_out <= `TSS_EXC_ILLEGAL_ADDR;
                end else begin
                    rsp_data_out     <= req_write_in ? `TSS_ZERO16 : next_rsp_data;
                    rsp_exc_out      <= 1'b0;
                    rsp_exc_code_out <= `TSS_EXC_NONE;
                end
            end
        end
    end

endmodule

//--- tss_status_monitor.sv
// Checker of the answer port of the status bank.
// Assumes it is bound to every tss_status_bank instance.
`timescale 1ns/100ps

module tss_status_monitor (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    // Request
    input wire logic        req_valid_in,
    input wire logic        req_write_in,
    input wire logic [15:0] req_addr_in,
    // Answer
    input wire logic        rsp_valid_out,
    input wire logic [15:0] rsp_data_out,
    input wire logic        rsp_exc_out,
    input wire logic [7:0]  rsp_exc_code_out,
    // Strap
    input wire logic [2:0]  pole_count_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    logic rq;
    logic flags;
    logic mapped;
    assign rq = req_valid_in && !req_write_in;
    assign flags = req_addr_in inside {[16'h03ed:16'h03f0]};
    assign mapped = flags || req_addr_in inside {16'h03e8, 16'h03ea, 16'h03ec,
        [16'h03fc:16'h03ff], 16'h044b};

    ////////////////////////////////////////////////////////////
    a_unmapped_refused: assert property (
        req_valid_in && !mapped |=> rsp_valid_out && rsp_exc_out && rsp_exc_code_out == 8'h02
    ) else $error("Unmapped address not refused");
    a_mapped_accepted: assert property (
        req_valid_in && mapped |=> rsp_valid_out && !rsp_exc_out && rsp_exc_code_out == 8'h00
    ) else $error("Mapped address refused");
    a_write_ignored: assert property (
        req_valid_in && req_write_in |=> rsp_data_out == 16'h0000
    ) else $error("Write returned data");
    a_upper_zero: assert property (
        rq && flags |=> rsp_data_out[15:8] == 8'h00
    ) else $error("Flag register upper byte set");
    a_pole_mask: assert property (
        rq && flags && pole_count_in != 3'h4 |=> !rsp_data_out[3] && rsp_data_out[1:0] == 2'b00
            && (pole_count_in == 3'h3 || !rsp_data_out[2])
    ) else $error("Pole dependent bit set");
    a_position_code: assert property (
        rq && req_addr_in == 16'h03e8 |=> rsp_data_out inside {16'h0000, 16'h0001,
            16'h0002, 16'h0004}
    ) else $error("Position code out of set");
    a_normal_range: assert property (
        rq && req_addr_in == 16'h03ea |=> rsp_data_out <= 16'h0002
    ) else $error("Normal state out of range");
    a_alternate_range: assert property (
        rq && req_addr_in == 16'h03ec |=> rsp_data_out <= 16'h0002
    ) else $error("Alternate state out of range");
    a_shed_range: assert property (
        rq && req_addr_in inside {16'h03fc, 16'h03fd} |=> rsp_data_out <= 16'h0001
    ) else $error("Shed value out of range");
    a_gen_range: assert property (
        rq && req_addr_in == 16'h03ff |=> rsp_data_out <= 16'h0002
    ) else $error("Generator state out of range");
    a_mode_range: assert property (
        rq && req_addr_in == 16'h044b |=> rsp_data_out <= 16'h0005
    ) else $error("Mode out of range");
endmodule

bind tss_status_bank tss_status_monitor u_mon (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .rsp_exc_out(rsp_exc_out),
    .rsp_exc_code_out(rsp_exc_code_out), .pole_count_in(pole_count_in));
